// *** design/ncwl_pkg.sv ***
// Constants for the configuration word loader: word indices, field
// positions, values after reset, bus offsets and timing counts.
// Assumes a 16-bit non-volatile word stream and a 40 MHz clock.
//
// What this block does
// - Device never computes or checks the checksum
// - Loaded configuration applies only with valid signature
// - Detection bit 14 zero enables deep idle saving
// - Control word bit 10 loads both wake enables
// - Control word bit 0 blocks PHY reset while keep-link-up is set
// - Own SMBus address from address word 15:9
// - Controller SMBus address from address word 7:1
// - Receive-enable bytes 14 and 13 from parameters word
// - Fragments never exceed programmed size plus one
// - Notification timeout counts from control word 7:0
// - Words 0x30 to 0x3E give no configuration
package ncwl_pkg;
  // ----------------------------------------------------------------
  // Word indices in the non-volatile image
  // ----------------------------------------------------------------
  localparam logic [15:0] WORD_DETECT = 16'h0023;
  localparam logic [15:0] WORD_INIT3 = 16'h0024;
  localparam logic [15:0] WORD_SMB_ADDR = 16'h0025;
  localparam logic [15:0] WORD_RX_EN = 16'h0026;
  localparam logic [15:0] WORD_SMB_CTRL = 16'h0027;
  localparam logic [15:0] WORD_SW_FIRST = 16'h0030;
  localparam logic [15:0] WORD_SW_LAST = 16'h003E;
  localparam logic [15:0] WORD_CHECKSUM = 16'h003F;
  localparam logic [15:0] CHECKSUM_TARGET = 16'hBABA;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DETECT_DEEP_IDLE_BIT = 14;
  localparam int INIT3_WAKE_BIT = 10;
  localparam int INIT3_NO_PHY_RST_BIT = 0;
  localparam int GCTRL_WAKE_BIT = 6;
  localparam int WUC_WAKE_BIT = 0;
  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic DEEP_IDLE_DIS_RST = 1'b1;
  localparam logic WAKE_EN_RST = 1'b0;
  localparam logic NO_PHY_RST_RST = 1'b1;
  localparam logic [6:0] SMB_ADDR_RST = 7'h00;
  localparam logic [7:0] RX_BYTE_RST = 8'h00;
  localparam logic [7:0] FRAG_SIZE_RST = 8'h20;
  localparam logic [7:0] NOTIFY_TO_RST = 8'h00;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_GEN_CTRL = 8'h00;
  localparam logic [7:0] OFS_WAKE_CTRL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_SMB_ADDR = 8'h0C;
  localparam logic [7:0] OFS_RX_EN = 8'h10;
  localparam logic [7:0] OFS_SMB_CTRL = 8'h14;
  // ----------------------------------------------------------------
  // Timing: one notification unit is at least 1.1 ms
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int NOTIFY_UNIT_NS = 1100000;
  localparam int NOTIFY_UNIT_CYC = (NOTIFY_UNIT_NS * 1000 +
                                    CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

// *** design/ncwl_loader.sv ***
// Configuration word loader: captures the detection, control and
// SMBus words as they stream in, applies them at the end of the load
// and drives the wake, PHY reset and SMBus controls from them.
// Assumes the word stream and the register port run on mclk.
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ncwl_loader #(
  parameter int NOTIFY_UNIT = ncwl_pkg::NOTIFY_UNIT_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Word stream from the non-volatile memory reader
  input wire logic nvmWordValid,
  input wire logic [15:0] nvmWordAddr,
  input wire logic [15:0] nvmWordData,
  input wire logic loadDone,
  input wire logic signatureValid,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // PHY reset control
  input wire logic keepLinkUpSetting,
  input wire logic phyResetReq,
  output logic phyResetOut,
  // Power saving
  output logic deepIdlePowerSave,
  output logic powerMgmtWakeEnable,
  // SMBus parameters
  output logic [6:0] smbOwnAddr,
  output logic [6:0] smbCtrlAddr,
  output logic [7:0] rxEnAlert,
  output logic [7:0] rxEnIfData,
  // Fragment limit
  input wire logic fragStart,
  input wire logic fragByte,
  output logic fragAllow,
  // Notification timeout
  input wire logic notifyStart,
  input wire logic notifyDone,
  output logic notifyBusy,
  output logic notifyTimeout
);

  // ----------------------------------------------------------------
  // Shadow words and applied configuration
  // ----------------------------------------------------------------
  logic deepIdleDis_r, deepIdleDisSh_r;
  logic wakeInit_r, noPhyRstSh_r, noPhyRst_r;
  logic [6:0] ownAddrSh_r, ctrlAddrSh_r;
  logic [7:0] alertSh_r, ifDataSh_r;
  logic [7:0] fragSizeSh_r, fragSize_r;
  logic [7:0] notifyToSh_r, notifyTo_r;
  logic applied_r;
  logic applyNow;
  logic genWake_r, wucWake_r;
  logic phyOut_r;
  logic [8:0] fragCount_r;
  logic [7:0] unitsLeft_r;
  logic [31:0] unitCount_r;
  logic notifyBusy_r, notifyTimeout_r;
  logic [31:0] rdata_r;

  // Word capture: only the configuration words are kept; the boot
  // pointer, software area and checksum word pass unread
  function automatic logic isWord(input logic [15:0] addr,
                                  input logic [15:0] idx);
    isWord = (addr == idx);
  endfunction

  // Configuration takes effect only at a load with a good signature
  // A register write in the same cycle as the apply is lost
  assign applyNow = loadDone & signatureValid;

  // ----------------------------------------------------------------
  // Word capture
  // ----------------------------------------------------------------

  // Capture detection word; only bit 14 is meaningful here
  // Shadows keep the last copy seen; a repeated word overwrites
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      deepIdleDisSh_r <= ncwl_pkg::DEEP_IDLE_DIS_RST;
    end else if (nvmWordValid &&
                 isWord(nvmWordAddr, ncwl_pkg::WORD_DETECT)) begin
      deepIdleDisSh_r <=
        nvmWordData[ncwl_pkg::DETECT_DEEP_IDLE_BIT];
    end
  end

  // Capture third initialisation control word: bits 10 and 0 only
  // The reserved bits around them never reach any control
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wakeInit_r <= ncwl_pkg::WAKE_EN_RST;
      noPhyRstSh_r <= ncwl_pkg::NO_PHY_RST_RST;
    end else if (nvmWordValid &&
                 isWord(nvmWordAddr, ncwl_pkg::WORD_INIT3)) begin
      wakeInit_r <= nvmWordData[ncwl_pkg::INIT3_WAKE_BIT];
      noPhyRstSh_r <= nvmWordData[ncwl_pkg::INIT3_NO_PHY_RST_BIT];
    end
  end

  // Capture SMBus address word; bits 8 and 0 are dropped
  // Both addresses sit in the upper seven bits of their byte
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ownAddrSh_r <= ncwl_pkg::SMB_ADDR_RST;
      ctrlAddrSh_r <= ncwl_pkg::SMB_ADDR_RST;
    end else if (nvmWordValid &&
                 isWord(nvmWordAddr, ncwl_pkg::WORD_SMB_ADDR)) begin
      ownAddrSh_r <= nvmWordData[15:9];
      ctrlAddrSh_r <= nvmWordData[7:1];
    end
  end

  // Capture receive-enable word: alert high byte, interface data low
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      alertSh_r <= ncwl_pkg::RX_BYTE_RST;
      ifDataSh_r <= ncwl_pkg::RX_BYTE_RST;
    end else if (nvmWordValid &&
                 isWord(nvmWordAddr, ncwl_pkg::WORD_RX_EN)) begin
      alertSh_r <= nvmWordData[15:8];
      ifDataSh_r <= nvmWordData[7:0];
    end
  end

  // Capture SMBus control word: fragment size high, timeout low
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fragSizeSh_r <= ncwl_pkg::FRAG_SIZE_RST;
      notifyToSh_r <= ncwl_pkg::NOTIFY_TO_RST;
    end else if (nvmWordValid &&
                 isWord(nvmWordAddr, ncwl_pkg::WORD_SMB_CTRL)) begin
      fragSizeSh_r <= nvmWordData[15:8];
      notifyToSh_r <= nvmWordData[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Apply at load completion
  // ----------------------------------------------------------------
  // Power and PHY controls; a load without signature leaves them
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      deepIdleDis_r <= ncwl_pkg::DEEP_IDLE_DIS_RST;
      noPhyRst_r <= ncwl_pkg::NO_PHY_RST_RST;
    end else if (applyNow) begin
      deepIdleDis_r <= deepIdleDisSh_r;
      noPhyRst_r <= noPhyRstSh_r;
    end
  end

  // SMBus addresses of this device and of the controller
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      smbOwnAddr <= ncwl_pkg::SMB_ADDR_RST;
      smbCtrlAddr <= ncwl_pkg::SMB_ADDR_RST;
    end else if (applyNow) begin
      smbOwnAddr <= ownAddrSh_r;
      smbCtrlAddr <= ctrlAddrSh_r;
    end
  end

  // Receive-enable bytes
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rxEnAlert <= ncwl_pkg::RX_BYTE_RST;
      rxEnIfData <= ncwl_pkg::RX_BYTE_RST;
    end else if (applyNow) begin
      rxEnAlert <= alertSh_r;
      rxEnIfData <= ifDataSh_r;
    end
  end

  // Fragment size; a size off the four-byte grid is used as written
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fragSize_r <= ncwl_pkg::FRAG_SIZE_RST;
    end else if (applyNow) begin
      fragSize_r <= fragSizeSh_r;
    end
  end

  // Notification timeout count in units
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      notifyTo_r <= ncwl_pkg::NOTIFY_TO_RST;
    end else if (applyNow) begin
      notifyTo_r <= notifyToSh_r;
    end
  end

  // Load status shown in the status register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      applied_r <= 1'b0;
    end else if (applyNow) begin
      applied_r <= 1'b1;
    end
  end

  // Deep idle saving runs while the disable bit is clear
  assign deepIdlePowerSave = ~deepIdleDis_r;

  // ----------------------------------------------------------------
  // Wake enables
  // ----------------------------------------------------------------

  // Wake enable in general control: loaded, then software writable
  // Apply wins over a software write in the same cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      genWake_r <= ncwl_pkg::WAKE_EN_RST;
    end else if (applyNow) begin
      genWake_r <= wakeInit_r;
    end else if (regWr && regAddr == ncwl_pkg::OFS_GEN_CTRL) begin
      genWake_r <= regWdata[ncwl_pkg::GCTRL_WAKE_BIT];
    end
  end

  // Wake enable in wake-up control: same initial value
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wucWake_r <= ncwl_pkg::WAKE_EN_RST;
    end else if (applyNow) begin
      wucWake_r <= wakeInit_r;
    end else if (regWr && regAddr == ncwl_pkg::OFS_WAKE_CTRL) begin
      wucWake_r <= regWdata[ncwl_pkg::WUC_WAKE_BIT];
    end
  end

  assign powerMgmtWakeEnable = wucWake_r;

  // ----------------------------------------------------------------
  // PHY reset gating
  // ----------------------------------------------------------------

  // PHY reset passes unless control word bit 0 and the keep-link-up setting block it together
  // Registered so the gating term cannot glitch the PHY line
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      phyOut_r <= 1'b0;
    end else begin
      phyOut_r <= phyResetReq &
                  ~(noPhyRst_r & keepLinkUpSetting);
    end
  end

  assign phyResetOut = phyOut_r;

  // ----------------------------------------------------------------
  // Fragment limit
  // ----------------------------------------------------------------

  // Fragment byte counter; at most size plus one bytes per fragment
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fragCount_r <= 9'h000;
    end else if (fragStart) begin
      fragCount_r <= 9'h000;
    end else if (fragByte && fragAllow) begin
      fragCount_r <= fragCount_r + 9'h001;
    end
  end

  // Two low size bits are taken as written by the image
  // A full count stays closed until the next fragment start or an apply that raises the size
  assign fragAllow = (fragCount_r <= {1'b0, fragSize_r});

  // ----------------------------------------------------------------
  // Notification timeout
  // ----------------------------------------------------------------

  // Notification timeout: value times one unit; zero means none
  // Done wins over a start in the same cycle; a start while busy restarts
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      notifyBusy_r <= 1'b0;
      notifyTimeout_r <= 1'b0;
      unitsLeft_r <= 8'h00;
      unitCount_r <= 32'h0000_0000;
    end else begin
      notifyTimeout_r <= 1'b0;
      if (notifyDone) begin
        notifyBusy_r <= 1'b0;
      end else if (notifyStart && notifyTo_r != 8'h00) begin
        notifyBusy_r <= 1'b1;
        unitsLeft_r <= notifyTo_r;
        unitCount_r <= 32'h0000_0000;
      end else if (notifyBusy_r) begin
        if (unitCount_r == 32'(NOTIFY_UNIT - 1)) begin
          unitCount_r <= 32'h0000_0000;
          if (unitsLeft_r == 8'h01) begin
            notifyBusy_r <= 1'b0;
            notifyTimeout_r <= 1'b1;
          end
          unitsLeft_r <= unitsLeft_r - 8'h01;
        end else begin
          unitCount_r <= unitCount_r + 32'h0000_0001;
        end
      end
    end
  end

  assign notifyBusy = notifyBusy_r;
  assign notifyTimeout = notifyTimeout_r;

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------

  // Read data stands one cycle after the read strobe, zero otherwise
  // Unmapped offsets read as zero; writes to status are dropped
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 32'h0000_0000;
    end else if (regRd) begin
      unique case (regAddr)
        ncwl_pkg::OFS_GEN_CTRL: rdata_r <= {25'h0, genWake_r, 6'h00};
        ncwl_pkg::OFS_WAKE_CTRL: rdata_r <= {31'h0, wucWake_r};
        ncwl_pkg::OFS_STATUS:
          rdata_r <= {28'h0, notifyBusy_r, noPhyRst_r, deepIdleDis_r,
                      applied_r};
        ncwl_pkg::OFS_SMB_ADDR:
          rdata_r <= {16'h0, smbOwnAddr, 1'b0, smbCtrlAddr, 1'b0};
        ncwl_pkg::OFS_RX_EN: rdata_r <= {16'h0, rxEnAlert, rxEnIfData};
        ncwl_pkg::OFS_SMB_CTRL: rdata_r <= {16'h0, fragSize_r, notifyTo_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign regRdata = rdata_r;

endmodule
`default_nettype wire

// *** verification/ncwl_nvm_model.sv ***
// Partner model: streams a 64-word image into the loader, then ends
// the load. Assumes go is a one-cycle request from the bench on mclk.
`timescale 1ns/1ps
`default_nettype none
module ncwl_nvm_model (
  // Control from the bench
  input wire logic mclk, resetn, go, sigOk, bad,
  input wire logic [79:0] cfg,
  // Word stream to the loader
  output logic vld, ld, sig,
  output logic [15:0] wa, wd
);
  logic [6:0] idx;
  logic busy, step;
  logic [15:0] sum, ck;
  // Image words; the software area holds junk, low byte 0xFF in word 0x23
  function automatic logic [15:0] word(input logic [5:0] a);
    if (a >= 6'h23 && a <= 6'h27) return cfg[16*(a-6'h23) +: 16];
    if (a == 6'h3D) return 16'h0040; // Boot structure start
    if (a >= 6'h30) return 16'hFFFF; // Software use only
    return {10'h000, a};
  endfunction
  // Sum of words 0x00..0x3E from zero, carries dropped
  always_comb begin
    sum = 16'h0000;
    for (int i = 0; i < 63; i++) sum = sum + word(i[5:0]);
  end
  // Checksum word brings the total to the target, bad breaks it
  assign ck = ncwl_pkg::CHECKSUM_TARGET - sum + {15'h0000, bad};
  assign step = busy && idx < 7'h40;
  // Stream one word a cycle; idle lines toggle rather than hold
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      {busy, vld, ld, sig} <= 4'h0;
      {idx, wa, wd} <= 39'h00_0000_0000;
    end else begin
      vld <= step;
      ld <= busy && !step;
      sig <= busy && !step && sigOk; // Signature gates the load
      wa <= step ? {9'h000, idx} : ~wa;
      wd <= !step ? ~wd : idx == 7'h3F ? ck : word(idx[5:0]);
      busy <= busy ? step : go;
      idx <= busy ? idx + 7'h01 : 7'h00;
    end
  end
endmodule
`default_nettype wire

// *** verification/ncwl_loader_monitor.sv ***
// Checker on the loader ports: PHY gating, load hold, fragment and
// notification timing. Bound below onto every loader instance.
`timescale 1ns/1ps
`default_nettype none
module ncwl_chk #(
  parameter int NOTIFY_UNIT = 4
) (
  // Clock, reset and strobes
  input wire logic mclk, resetn, regWr, loadDone,
  // PHY and loaded controls
  input wire logic keepLinkUpSetting, phyResetReq, phyResetOut,
  input wire logic deepIdlePowerSave, powerMgmtWakeEnable,
  input wire logic [6:0] smbOwnAddr, smbCtrlAddr,
  // Fragment and notification
  input wire logic fragStart, fragAllow, notifyStart, notifyDone,
  input wire logic notifyBusy, notifyTimeout
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // Sequences and assertions
  // ----------------------------------------------------------------
  sequence s_quiet;
    !$past(loadDone) && !$past(regWr);
  endsequence
  sequence s_pulse;
    !notifyBusy ##1 !notifyTimeout;
  endsequence
  chk_phy_quiet: assert property (
    !$past(phyResetReq) |-> !phyResetOut)
    else $error("PHY reset without request");
  chk_phy_free: assert property (
    $past(phyResetReq && !keepLinkUpSetting) |-> phyResetOut)
    else $error("PHY reset blocked without keep setting");
  chk_addr_hold: assert property (
    s_quiet |-> $stable(smbOwnAddr) && $stable(smbCtrlAddr))
    else $error("SMBus address changed without load");
  chk_idle_hold: assert property (
    s_quiet |-> $stable(deepIdlePowerSave))
    else $error("deep idle changed without load");
  chk_wake_hold: assert property (
    s_quiet |-> $stable(powerMgmtWakeEnable))
    else $error("wake enable changed without load");
  chk_frag_clear: assert property (
    fragStart |=> fragAllow)
    else $error("fragment not allowed after start");
  chk_frag_stop: assert property (
    !fragAllow && !fragStart && !loadDone && !regWr |=> !fragAllow)
    else $error("fragment allowed again past limit");
  chk_tmo_pulse: assert property (
    notifyTimeout |-> s_pulse)
    else $error("timeout not a single pulse ending busy");
  chk_tmo_cause: assert property (
    notifyTimeout |-> $past(notifyBusy))
    else $error("timeout without busy");
  chk_done_cancel: assert property (
    notifyDone && !notifyStart |=> !notifyBusy)
    else $error("done did not cancel wait");
endmodule
// Attach to every loader
bind ncwl_loader ncwl_chk #(.NOTIFY_UNIT(NOTIFY_UNIT)) u_chk (
  .mclk(mclk), .resetn(resetn), .regWr(regWr), .loadDone(loadDone),
  .keepLinkUpSetting(keepLinkUpSetting), .phyResetReq(phyResetReq),
  .phyResetOut(phyResetOut), .deepIdlePowerSave(deepIdlePowerSave),
  .powerMgmtWakeEnable(powerMgmtWakeEnable), .smbOwnAddr(smbOwnAddr),
  .smbCtrlAddr(smbCtrlAddr), .fragStart(fragStart), .fragAllow(fragAllow),
  .notifyStart(notifyStart), .notifyDone(notifyDone),
  .notifyBusy(notifyBusy), .notifyTimeout(notifyTimeout));
`default_nettype wire

// *** verification/tb.sv ***
// Testbench: loads images through the partner model and checks the
// applied controls over the register port. Assumes a 40 MHz mclk.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int NU = 4;
  logic mclk = 1'h0, resetn = 1'h0, go = 1'h0, sigOk = 1'h0, bad = 1'h0;
  logic regWr = 1'h0, regRd = 1'h0, keep = 1'h0, req = 1'h0;
  logic fs = 1'h0, fb = 1'h0, ns = 1'h0, nd = 1'h0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0000_0000;
  // Validity bit 15 clear, fragment size 0x1C on the four-byte grid
  logic [79:0] cfg = 80'h1C01_A55A_FF05_FFFE_3FFF;
  logic vld, ld, sig, phy, idle, wake, fa, nb, nt;
  logic [15:0] wa, wd;
  logic [31:0] regRdata;
  logic [6:0] own, ctl;
  logic [7:0] al, ifd;
  int error_cnt = 0;
  int comparisons = 0;
  int n;
  ncwl_nvm_model u_nvm (.mclk(mclk), .resetn(resetn), .go(go), .sigOk(sigOk),
    .bad(bad), .cfg(cfg), .vld(vld), .ld(ld), .sig(sig), .wa(wa), .wd(wd));
  ncwl_loader #(.NOTIFY_UNIT(NU)) u_dut (.mclk(mclk), .resetn(resetn),
    .nvmWordValid(vld), .nvmWordAddr(wa), .nvmWordData(wd), .loadDone(ld),
    .signatureValid(sig), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .keepLinkUpSetting(keep), .phyResetReq(req), .phyResetOut(phy),
    .deepIdlePowerSave(idle), .powerMgmtWakeEnable(wake), .smbOwnAddr(own),
    .smbCtrlAddr(ctl), .rxEnAlert(al), .rxEnIfData(ifd), .fragStart(fs),
    .fragByte(fb), .fragAllow(fa), .notifyStart(ns), .notifyDone(nd),
    .notifyBusy(nb), .notifyTimeout(nt));
  // ----------------------------------------------------------------
  // Clock, tasks and watchdog
  // ----------------------------------------------------------------
  initial forever #12.5 mclk = ~mclk;
  task automatic chk(input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk) {regWr, regAddr, regWdata} <= {1'h1, a, d};
    @(posedge mclk) regWr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk) {regRd, regAddr} <= {1'h1, a};
    @(posedge mclk) regRd <= 1'h0;
    #1 chk(regRdata, e);
  endtask
  task automatic load(input logic s, b);
    @(posedge mclk) {go, sigOk, bad} <= {1'h1, s, b};
    @(posedge mclk) go <= 1'h0;
    for (n = 0; ld !== 1'h1 && n < 200; n++) @(posedge mclk) #1;
    if (n == 200) error_cnt++; // Load never ended
    @(posedge mclk) #1;
  endtask
  task automatic physet(input logic k, e);
    @(posedge mclk) {keep, req} <= {k, 1'h1};
    repeat (2) @(posedge mclk);
    #1 chk(phy, e);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Cut a hang short well past the expected run
  initial begin
    #500000;
    error_cnt++;
    end_sim;
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'h1;
    rd(8'h08, 32'h0000_0006);
    rd(8'h14, 32'h0000_2000);
    physet(1'h1, 1'h0);
    physet(1'h0, 1'h1);
    @(posedge mclk) ns <= 1'h1;
    @(posedge mclk) ns <= 1'h0;
    #1 chk(nb, 1'h0);
    $display("test reset and PHY defaults done");
    load(1'h0, 1'h0);
    rd(8'h0C, 32'h0000_0000);
    load(1'h1, 1'h1);
    chk(own, 7'h7F);
    chk(ctl, 7'h02);
    chk({al, ifd}, 16'hA55A);
    chk({idle, wake}, 2'h3);
    rd(8'h00, 32'h0000_0040);
    rd(8'h0C, 32'h0000_FE04);
    rd(8'h14, 32'h0000_1C01);
    rd(8'h08, 32'h0000_0001);
    physet(1'h1, 1'h1);
    wr(8'h04, 32'h0000_0000);
    wr(8'h08, 32'h0000_000F);
    rd(8'h20, 32'h0000_0000);
    rd(8'h08, 32'h0000_0001);
    chk(wake, 1'h0);
    $display("test image load and registers done");
    @(posedge mclk) fs <= 1'h1;
    @(posedge mclk) {fs, fb} <= 2'h1;
    repeat (28) @(posedge mclk);
    #1 chk(fa, 1'h1);
    @(posedge mclk) fb <= 1'h0;
    #1 chk(fa, 1'h0);
    $display("test fragment limit done");
    @(posedge mclk) ns <= 1'h1;
    @(posedge mclk) ns <= 1'h0;
    for (n = 0; nt !== 1'h1 && n < 20; n++) @(posedge mclk) #1;
    // One unit of NU cycles after the edge that takes the start
    chk(n, NU);
    @(posedge mclk) ns <= 1'h1;
    @(posedge mclk) {ns, nd} <= 2'h1;
    @(posedge mclk) nd <= 1'h0;
    for (n = 0; nt !== 1'h1 && n < 12; n++) @(posedge mclk) #1;
    chk({nb, nt}, 2'h0);
    $display("test notification timeout done");
    end_sim;
  end
endmodule
`default_nettype wire
